//--- src/csf_core.sv
// Status flags, call shadows and operand address forming
`timescale 1ns/1ps
`include "csf_cfg.svh"
module csf_core (
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    input  csf_pkg::csf_instr_s   instr_i,
    input  wire logic [7:0]       file_rdata_i,
    input  wire logic             wdt_clear_i,
    input  wire logic             sleep_i,
    input  wire logic             wdt_timeout_i,
    input  wire logic             ext_set_i,
    output logic [13:0]           rd_addr_o,
    output csf_pkg::csf_wb_s      wb_o,
    output logic [7:0]            arithmetic_flags_o,
    output logic [7:0]            working_register_o,
    output logic [5:0]            bank_select_register_o,
    output logic [7:0]            call_shadow_working_o,
    output logic [5:0]            call_shadow_bank_o,
    output logic [7:0]            call_shadow_flags_o,
    output logic [19:0]           call_target_o,
    output logic                  call_o
);
    logic [7:0]  flags_q;       // Flag register, bit 7 always zero
    logic [7:0]  work_q;        // Working register
    logic [5:0]  bank_q;        // Bank select
    logic [7:0]  csh_work_q;    // Call shadow of working
    logic [5:0]  csh_bank_q;    // Call shadow of bank
    logic [7:0]  csh_flags_q;   // Call shadow of flags
    logic [13:0] op_addr;       // Operand data address
    logic [7:0]  alu_a;         // First operand
    logic [7:0]  alu_res;       // Unit result
    logic [4:0]  alu_flags;     // Computed flag values
    logic [4:0]  alu_touch;     // Flags the operation changes
    logic        to_flags;      // File write targets flag register
    logic        file_we;       // File write enabled
    logic        ind;           // Indirect access this cycle
    logic [13:0] paddr [2:0];   // Pointer access addresses
    logic [13:0] pval [2:0];    // Pointer stored values
    logic [7:0]  fl_d;          // Next flag register

    // Operand address from mode; literal offset needs extended set
    always_comb begin
        op_addr = 14'h0000;
        ind = 1'b0;
        case (instr_i.mode)
            csf_pkg::CSF_AM_DIRECT: begin
                if (instr_i.access_bit) begin
                    op_addr = {bank_q, instr_i.file_addr};
                end else if (ext_set_i &&
                             instr_i.file_addr < `CSF_ACCESS_SPLIT) begin
                    // Pointer 2 plus literal offset
                    op_addr = pval[2] + {6'h00, instr_i.file_addr};
                end else if (instr_i.file_addr < `CSF_ACCESS_SPLIT) begin
                    op_addr = {6'h00, instr_i.file_addr};
                end else begin
                    op_addr = {`CSF_ACCESS_HIGH, instr_i.file_addr};
                end
            end
            csf_pkg::CSF_AM_LONG: begin
                op_addr = instr_i.long_addr;
            end
            csf_pkg::CSF_AM_IND: begin
                ind = 1'b1;
                op_addr = paddr[instr_i.ptr_sel];
            end
            default: begin
                op_addr = 14'h0000;
            end
        endcase
    end
    assign rd_addr_o = op_addr;

    // Three pointer pairs
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_ptr
            logic [13:0] base;
            assign base = `CSF_PTR0_ADDR - 14'(3 * g);
            csf_ptr u_ptr (
                .clk_i     (clk_i),
                .sys_rst_i (sys_rst_i),
                .act_i     (instr_i.valid && ind &&
                            instr_i.ptr_sel == 2'(g)),
                .pa_i      (instr_i.ptr_act),
                .wr_lo_i   (file_we && wb_o.file_addr == base),
                .wr_hi_i   (file_we &&
                            wb_o.file_addr == base + 14'h0001),
                .wdata_i   (alu_res),
                .addr_o    (paddr[g]),
                .ptr_o     (pval[g])
            );
        end
    endgenerate

    assign alu_a = instr_i.use_literal ? instr_i.literal : file_rdata_i;
    csf_alu u_alu (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .op_i      (instr_i.op),
        .a_i       (alu_a),
        .b_i       (work_q),
        .carry_i   (flags_q[`CSF_BIT_CRY]),
        .res_o     (alu_res),
        .flags_o   (alu_flags),
        .touch_o   (alu_touch)
    );

    // Write-back routing by the destination bit
    assign to_flags = (op_addr == `CSF_FLAGS_ADDR) &&
                      !instr_i.use_literal;
    // Result dropped when flags are destination and touched
    assign file_we = instr_i.valid && instr_i.dest_bit &&
                     instr_i.mode != csf_pkg::CSF_AM_NONE &&
                     !(to_flags && alu_touch != 5'h00);
    always_comb begin
        wb_o.file_we   = file_we && !to_flags;
        wb_o.file_addr = op_addr;
        wb_o.file_data = alu_res;
        wb_o.work_we   = instr_i.valid && !instr_i.dest_bit &&
                         instr_i.op != csf_pkg::CSF_OP_NONE;
    end

    // Next flags: direct writes then flag effects, same cycle
    always_comb begin
        fl_d = flags_q;
        if (file_we && to_flags) begin
            // Only the low five bits are writable
            fl_d[4:0] = alu_res[4:0];
        end
        if (instr_i.valid) begin
            // Pointer steps bypass this path entirely
            fl_d[4:0] = (fl_d[4:0] & ~alu_touch) |
                        (alu_flags & alu_touch);
        end
        if (wdt_clear_i) begin
            fl_d[`CSF_BIT_TMO] = 1'b1;
            fl_d[`CSF_BIT_PWD] = 1'b1;
        end else if (sleep_i) begin
            fl_d[`CSF_BIT_TMO] = 1'b1;
            fl_d[`CSF_BIT_PWD] = 1'b0;
        end
        if (wdt_timeout_i) begin
            fl_d[`CSF_BIT_TMO] = 1'b0;
        end
        fl_d[7] = 1'b0;
    end

    // Flag register, power-up sets timeout and powerdown
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            flags_q <= `CSF_FLAGS_RST;
        end else begin
            flags_q <= fl_d;
        end
    end

    // Working register and bank select
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            work_q <= 8'h00;
            bank_q <= 6'h00;
        end else if (wb_o.work_we) begin
            work_q <= alu_res;
        end
    end

    // Call shadows captured on any call kind
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            csh_work_q  <= 8'h00;
            csh_bank_q  <= 6'h00;
            csh_flags_q <= 8'h00;
        end else if (instr_i.valid && instr_i.is_call) begin
            csh_work_q  <= work_q;
            csh_bank_q  <= bank_q;
            csh_flags_q <= flags_q;
        end
    end

    // Absolute target carried as a 20-bit literal
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            call_target_o <= 20'h00000;
            call_o        <= 1'b0;
        end else begin
            call_o <= instr_i.valid && instr_i.is_call;
            if (instr_i.valid && instr_i.is_call) begin
                call_target_o <= instr_i.call_target;
            end
        end
    end

    assign arithmetic_flags_o     = flags_q;
    assign working_register_o     = work_q;
    assign bank_select_register_o = bank_q;
    assign call_shadow_working_o  = csh_work_q;
    assign call_shadow_bank_o     = csh_bank_q;
    assign call_shadow_flags_o    = csh_flags_q;

    sequence s_call;
        instr_i.valid && instr_i.is_call;
    endsequence
    property p_shadow;
        @(posedge clk_i) disable iff (sys_rst_i)
        s_call |=> csh_flags_q == $past(flags_q) &&
                   csh_work_q == $past(work_q);
    endproperty
    a_shadow: assert property (p_shadow)
        else $error("call shadow not captured");
    property p_bit7;
        @(posedge clk_i) disable iff (sys_rst_i) flags_q[7] == 1'b0;
    endproperty
    a_bit7: assert property (p_bit7)
        else $error("flag bit seven set");
    property p_sleep;
        @(posedge clk_i) disable iff (sys_rst_i)
        sleep_i && !wdt_clear_i && !wdt_timeout_i |=>
            flags_q[6:5] == 2'b10;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("sleep flags wrong");
    property p_tmo;
        @(posedge clk_i) disable iff (sys_rst_i)
        wdt_timeout_i |=> !flags_q[6];
    endproperty
    a_tmo: assert property (p_tmo)
        else $error("timeout did not clear bit");
    property p_drop;
        @(posedge clk_i) disable iff (sys_rst_i)
        to_flags && alu_touch != 5'h00 |-> !wb_o.file_we;
    endproperty
    a_drop: assert property (p_drop)
        else $error("result written to flag register");
    property p_long;
        @(posedge clk_i) disable iff (sys_rst_i)
        instr_i.mode == csf_pkg::CSF_AM_LONG |->
            rd_addr_o == instr_i.long_addr;
    endproperty
    a_long: assert property (p_long)
        else $error("long address altered");
    property p_zero;
        @(posedge clk_i) disable iff (sys_rst_i)
        instr_i.valid && alu_touch[2] && !wdt_clear_i |=>
            flags_q[2] == ($past(alu_res) == 8'h00);
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero flag wrong");
endmodule : csf_core

//--- src/csf_cfg.svh
// Constants for the status flag and data addressing block
`ifndef CSF_CFG_SVH
`define CSF_CFG_SVH
`define CSF_BIT_TMO      3'd6
`define CSF_BIT_PWD      3'd5
`define CSF_BIT_NEG      3'd4
`define CSF_BIT_OVF      3'd3
`define CSF_BIT_ZRO      3'd2
`define CSF_BIT_DCY      3'd1
`define CSF_BIT_CRY      3'd0
`define CSF_FLAGS_RST    8'h60
`define CSF_ALU_MASK     8'h1f
`define CSF_ACCESS_SPLIT 8'h60
`define CSF_ACCESS_HIGH  6'h3f
`define CSF_FLAGS_ADDR   14'h3fd8
`define CSF_PTR0_ADDR    14'h3fe9
`define CSF_PTR_MASK     6'h3f
`endif

//--- src/csf_pkg.sv
// Types shared by the status flag and data addressing block
package csf_pkg;
    // Arithmetic and flag operations
    typedef enum logic [3:0] {
        CSF_OP_NONE = 4'h0,
        CSF_OP_ADD  = 4'h1,
        CSF_OP_SUB  = 4'h2,
        CSF_OP_AND  = 4'h3,
        CSF_OP_IOR  = 4'h4,
        CSF_OP_XOR  = 4'h5,
        CSF_OP_CLR  = 4'h6,
        CSF_OP_RRC  = 4'h7,
        CSF_OP_RLC  = 4'h8,
        CSF_OP_MOV  = 4'h9
    } csf_op_e;
    // Operand address mode
    typedef enum logic [3:0] {
        CSF_AM_DIRECT = 4'b0001,
        CSF_AM_LONG   = 4'b0010,
        CSF_AM_IND    = 4'b0100,
        CSF_AM_NONE   = 4'b1000
    } csf_am_e;
    // Pointer action during indirect access
    typedef enum logic [1:0] {
        CSF_PA_KEEP = 2'd0,
        CSF_PA_POST_INC = 2'd1,
        CSF_PA_POST_DEC = 2'd2,
        CSF_PA_PRE_INC  = 2'd3
    } csf_pa_e;
    // One issued instruction
    typedef struct packed {
        logic       valid;
        csf_op_e    op;
        csf_am_e    mode;
        logic       access_bit;
        logic       dest_bit;
        logic [7:0] file_addr;
        logic [13:0] long_addr;
        logic [1:0] ptr_sel;
        csf_pa_e    ptr_act;
        logic [7:0] literal;
        logic       use_literal;
        logic       is_call;
        logic [19:0] call_target;
    } csf_instr_s;
    // Result write-back
    typedef struct packed {
        logic        file_we;
        logic [13:0] file_addr;
        logic [7:0]  file_data;
        logic        work_we;
    } csf_wb_s;
endpackage : csf_pkg

//--- src/csf_alu.sv
// Arithmetic unit producing result and flag effects
`timescale 1ns/1ps
`include "csf_cfg.svh"
module csf_alu (
    input  wire logic           clk_i,
    input  wire logic           sys_rst_i,
    input  csf_pkg::csf_op_e    op_i,
    input  wire logic [7:0]     a_i,
    input  wire logic [7:0]     b_i,
    input  wire logic           carry_i,
    output logic [7:0]          res_o,
    output logic [4:0]          flags_o,
    output logic [4:0]          touch_o
);
    logic [8:0] sum;    // Nine bits keep the carry out
    logic [4:0] low;    // Low nibble with digit carry
    logic [7:0] bop;    // Second operand, complemented on subtract
    logic       cin;    // Carry in, one on subtract
    // Subtract adds the two's complement of the second operand
    always_comb begin
        bop = (op_i == csf_pkg::CSF_OP_SUB) ? ~b_i : b_i;
        cin = (op_i == csf_pkg::CSF_OP_SUB);
        sum = {1'b0, a_i} + {1'b0, bop} + {8'h00, cin};
        low = {1'b0, a_i[3:0]} + {1'b0, bop[3:0]} + {4'h0, cin};
    end
    // Result and flag effects per operation
    always_comb begin
        res_o   = 8'h00;
        flags_o = 5'h00;
        touch_o = 5'h00;
        case (op_i)
            csf_pkg::CSF_OP_ADD, csf_pkg::CSF_OP_SUB: begin
                res_o = sum[7:0];
                flags_o[0] = sum[8];
                flags_o[1] = low[4];
                // Sign flips against both like-signed inputs
                flags_o[3] = (a_i[7] == bop[7]) && (sum[7] != a_i[7]);
                touch_o = 5'h1f;
            end
            csf_pkg::CSF_OP_AND: begin
                res_o = a_i & b_i;
                touch_o = 5'h14;
            end
            csf_pkg::CSF_OP_IOR: begin
                res_o = a_i | b_i;
                touch_o = 5'h14;
            end
            csf_pkg::CSF_OP_XOR: begin
                res_o = a_i ^ b_i;
                touch_o = 5'h14;
            end
            csf_pkg::CSF_OP_CLR: begin
                res_o = 8'h00;
                touch_o = 5'h04;
            end
            csf_pkg::CSF_OP_RRC: begin
                res_o = {carry_i, a_i[7:1]};
                flags_o[0] = a_i[0];
                touch_o = 5'h15;
            end
            csf_pkg::CSF_OP_RLC: begin
                res_o = {a_i[6:0], carry_i};
                flags_o[0] = a_i[7];
                touch_o = 5'h15;
            end
            csf_pkg::CSF_OP_MOV: begin
                res_o = a_i;
            end
            default: begin
                res_o = 8'h00;
            end
        endcase
        flags_o[4] = res_o[7];
        flags_o[2] = (res_o == 8'h00);
    end
    // Clearing touches the zero flag alone and sets it
    property p_clr_zero;
        @(posedge clk_i) disable iff (sys_rst_i)
        op_i == csf_pkg::CSF_OP_CLR |-> touch_o == 5'h04 && flags_o[2];
    endproperty
    a_clr_zero: assert property (p_clr_zero)
        else $error("clear must touch only zero");
    // Equal operands subtract with no borrow, so both carries read one
    property p_sub_eq;
        @(posedge clk_i) disable iff (sys_rst_i)
        op_i == csf_pkg::CSF_OP_SUB && a_i == b_i |->
            flags_o[0] && flags_o[1] && flags_o[2];
    endproperty
    a_sub_eq: assert property (p_sub_eq)
        else $error("subtract of equal operands borrowed");
endmodule : csf_alu

//--- src/csf_ptr.sv
// One file select pointer pair with auto modify
`timescale 1ns/1ps
`include "csf_cfg.svh"
module csf_ptr (
    input  wire logic           clk_i,
    input  wire logic           sys_rst_i,
    input  wire logic           act_i,
    input  csf_pkg::csf_pa_e    pa_i,
    input  wire logic           wr_lo_i,
    input  wire logic           wr_hi_i,
    input  wire logic [7:0]     wdata_i,
    output logic [13:0]         addr_o,
    output logic [13:0]         ptr_o
);
    logic [13:0] ptr_q;    // Pointer, top two high-byte bits absent
    assign ptr_o  = ptr_q;
    // Pre-increment uses the bumped value
    assign addr_o = (pa_i == csf_pkg::CSF_PA_PRE_INC) ?
                    ptr_q + 14'h0001 : ptr_q;
    // Whole-pair modify; a direct write wins over any auto step
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ptr_q <= 14'h0000;
        end else if (wr_lo_i || wr_hi_i) begin
            if (wr_lo_i) ptr_q[7:0] <= wdata_i;
            if (wr_hi_i) ptr_q[13:8] <= wdata_i[5:0];
        end else if (act_i) begin
            case (pa_i)
                csf_pkg::CSF_PA_POST_INC,
                csf_pkg::CSF_PA_PRE_INC: begin
                    ptr_q <= ptr_q + 14'h0001;
                end
                csf_pkg::CSF_PA_POST_DEC: begin
                    ptr_q <= ptr_q - 14'h0001;
                end
                default: begin
                    ptr_q <= ptr_q;
                end
            endcase
        end
    end
    // Post increment steps the whole pair by one
    property p_inc;
        @(posedge clk_i) disable iff (sys_rst_i)
        act_i && !wr_lo_i && !wr_hi_i && pa_i == csf_pkg::CSF_PA_POST_INC
        |=> ptr_q == $past(ptr_q) + 14'h0001;
    endproperty
    a_inc: assert property (p_inc)
        else $error("post increment did not step pair");
    // Post decrement borrows across the byte boundary as well
    property p_dec;
        @(posedge clk_i) disable iff (sys_rst_i)
        act_i && !wr_lo_i && !wr_hi_i && pa_i == csf_pkg::CSF_PA_POST_DEC
        |=> ptr_q == $past(ptr_q) - 14'h0001;
    endproperty
    a_dec: assert property (p_dec)
        else $error("post decrement did not step pair");
endmodule : csf_ptr

//--- testbench/cpu_status_flags_and_data_addressing_test.sv
// Self-checking bench for the status flag and addressing core
`timescale 1ns/1ps
module cpu_status_flags_and_data_addressing_test;
    // Row of the arithmetic table: operands beside expected result/flags
    typedef struct packed {
        csf_pkg::csf_op_e op;
        logic [7:0]       f;
        logic [7:0]       w;
        logic [7:0]       res;
        logic [4:0]       flg;
    } csf_row_s;
    // Flags are {negative, overflow, zero, digit carry, carry}
    localparam csf_row_s rows [6] = '{
        '{csf_pkg::CSF_OP_ADD, 8'h0f, 8'h01, 8'h10, 5'b00010},
        '{csf_pkg::CSF_OP_ADD, 8'h7f, 8'h01, 8'h80, 5'b11010},
        '{csf_pkg::CSF_OP_ADD, 8'hff, 8'h01, 8'h00, 5'b00111},
        '{csf_pkg::CSF_OP_SUB, 8'h05, 8'h05, 8'h00, 5'b00111},
        '{csf_pkg::CSF_OP_SUB, 8'h03, 8'h05, 8'hfe, 5'b10000},
        '{csf_pkg::CSF_OP_SUB, 8'h80, 8'h01, 8'h7f, 5'b01001}};
    logic                clk_i;          // System clock
    logic                sys_rst_i;      // Async reset, high
    csf_pkg::csf_instr_s instr_i;        // Issued instruction
    logic [7:0]          file_rdata_i;   // Operand read data
    logic                wdt_clear_i;    // Watchdog clear event
    logic                sleep_i;        // Sleep event
    logic                wdt_timeout_i;  // Watchdog time-out event
    logic                ext_set_i;      // Extended set, on only in the literal offset test
    logic [13:0]         rd_addr;        // Operand address
    csf_pkg::csf_wb_s    wb;             // Write-back
    logic [7:0]          flags;          // Flag register
    logic [7:0]          work;           // Working register
    logic [5:0]          bank;           // Bank select
    logic [7:0]          sh_w;           // Shadow of working
    logic [5:0]          sh_b;           // Shadow of bank
    logic [7:0]          sh_f;           // Shadow of flags
    logic [19:0]         tgt;            // Call target
    logic                call;           // Call pulse
    int                  errors;         // Mismatch count
    int                  comparisons;    // Comparison count
    logic [7:0]          fsave;          // Flags saved before a step
    csf_pkg::csf_instr_s nop;            // Idle instruction
    csf_pkg::csf_instr_s ins;            // Scratch instruction
    csf_pkg::csf_pa_e    acts [6];       // Pointer action sequence
    logic [13:0]         pexp [6];       // Expected pointer addresses

    csf_core u_dut (
        .clk_i                  (clk_i),
        .sys_rst_i              (sys_rst_i),
        .instr_i                (instr_i),
        .file_rdata_i           (file_rdata_i),
        .wdt_clear_i            (wdt_clear_i),
        .sleep_i                (sleep_i),
        .wdt_timeout_i          (wdt_timeout_i),
        .ext_set_i              (ext_set_i),
        .rd_addr_o              (rd_addr),
        .wb_o                   (wb),
        .arithmetic_flags_o     (flags),
        .working_register_o     (work),
        .bank_select_register_o (bank),
        .call_shadow_working_o  (sh_w),
        .call_shadow_bank_o     (sh_b),
        .call_shadow_flags_o    (sh_f),
        .call_target_o          (tgt),
        .call_o                 (call)
    );

    // 200 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // Builds an instruction; unused fields stay zero
    function automatic csf_pkg::csf_instr_s mk(csf_pkg::csf_op_e op,
        csf_pkg::csf_am_e am, logic acc, logic dst, logic [7:0] fa);
        csf_pkg::csf_instr_s i;
        i = '0;
        i.valid = 1'b1;
        i.op = op;
        i.mode = am;
        i.access_bit = acc;
        i.dest_bit = dst;
        i.file_addr = fa;
        return i;
    endfunction : mk

    // Compare and count; four-state so an unknown never matches
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Drive on the falling edge, then let combinational outputs settle
    task automatic go(csf_pkg::csf_instr_s i, logic [7:0] rd);
        @(negedge clk_i);
        instr_i = i;
        file_rdata_i = rd;
        #1;
    endtask : go

    // Pass the taking edge and let registers land
    task automatic tick;
        @(posedge clk_i);
        #1;
    endtask : tick

    // Move a value into the working register (destination bit low)
    task automatic ldw(logic [7:0] v);
        go(mk(csf_pkg::CSF_OP_MOV, csf_pkg::CSF_AM_DIRECT, 1'b1, 1'b0,
              8'h10), v);
        chk(wb.work_we, 1'b1);
        chk(wb.file_we, 1'b0);
        tick();
        chk(work, v);
    endtask : ldw

    // Logic op on file with working, checks data and {negative, zero}
    task automatic lop(csf_pkg::csf_op_e op, logic [7:0] f,
                       logic [7:0] r, logic [1:0] nz);
        go(mk(op, csf_pkg::CSF_AM_DIRECT, 1'b0, 1'b1, 8'h10), f);
        chk(wb.file_data, r);
        tick();
        chk({flags[4], flags[2]}, nz);
    endtask : lop

    // One-cycle event pulse {clear, sleep, time-out}, idle instruction
    task automatic evt(logic [2:0] e);
        @(negedge clk_i);
        instr_i = nop;
        {wdt_clear_i, sleep_i, wdt_timeout_i} = e;
        tick();
        @(negedge clk_i);
        {wdt_clear_i, sleep_i, wdt_timeout_i} = 3'b000;
    endtask : evt

    // Print counts and verdict, then stop
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    // Watchdog: the whole run needs under a hundred cycles
    initial begin
        #5000;
        errors++;
        end_sim();
    end

    // Main sequence
    initial begin
        errors = 0;
        comparisons = 0;
        nop = '0;
        instr_i = '0;
        file_rdata_i = 8'h00;
        {wdt_clear_i, sleep_i, wdt_timeout_i} = 3'b000;
        ext_set_i = 1'b0;
        sys_rst_i = 1'b1;
        repeat (16) @(posedge clk_i);
        @(negedge clk_i);
        sys_rst_i = 1'b0;
        chk(flags, 8'h60);
        chk({work, bank, sh_w}, 22'h0);
        $display("reset test done");
        // Arithmetic table, result written back to the file
        for (int k = 0; k < 6; k++) begin
            ldw(rows[k].w);
            go(mk(rows[k].op, csf_pkg::CSF_AM_DIRECT, 1'b0, 1'b1, 8'h10),
               rows[k].f);
            chk(rd_addr, 14'h0010);
            chk({wb.file_we, wb.file_addr}, {1'b1, 14'h0010});
            chk(wb.file_data, rows[k].res);
            tick();
            chk(flags[4:3], rows[k].flg[4:3]);
            chk(flags[2], rows[k].flg[2]);
            chk(flags[1:0], rows[k].flg[1:0]);
            chk(flags[7:5], 3'b011);
        end
        $display("arithmetic table done");
        // Clear with the flag register as destination: 0uuu u1uu
        go(mk(csf_pkg::CSF_OP_CLR, csf_pkg::CSF_AM_DIRECT, 1'b0, 1'b1,
              8'hd8), 8'h55);
        chk(rd_addr, 14'h3fd8);
        chk(wb.file_we, 1'b0);
        tick();
        chk(flags, 8'h6d);
        // Move all ones in: top three bits must not follow
        go(mk(csf_pkg::CSF_OP_MOV, csf_pkg::CSF_AM_DIRECT, 1'b0, 1'b1,
              8'hd8), 8'hff);
        tick();
        chk(flags, 8'h7f);
        $display("flag destination test done");
        // Rotates through carry, carry is set on entry
        go(mk(csf_pkg::CSF_OP_RLC, csf_pkg::CSF_AM_DIRECT, 1'b0, 1'b1,
              8'h10), 8'h80);
        chk(wb.file_data, 8'h01);
        tick();
        chk(flags[0], 1'b1);
        go(mk(csf_pkg::CSF_OP_RRC, csf_pkg::CSF_AM_DIRECT, 1'b0, 1'b1,
              8'h10), 8'h02);
        chk(wb.file_data, 8'h81);
        tick();
        chk(flags[0], 1'b0);
        ldw(8'h0f);
        lop(csf_pkg::CSF_OP_AND, 8'hf0, 8'h00, 2'b01);
        lop(csf_pkg::CSF_OP_XOR, 8'hf0, 8'hff, 2'b10);
        lop(csf_pkg::CSF_OP_IOR, 8'h00, 8'h0f, 2'b00);
        // Literal operand replaces the file data
        ins = mk(csf_pkg::CSF_OP_ADD, csf_pkg::CSF_AM_NONE, 1'b0, 1'b0,
                 8'h00);
        ins.use_literal = 1'b1;
        ins.literal = 8'h01;
        go(ins, 8'hff);
        tick();
        chk(work, 8'h10);
        $display("rotate and logic test done");
        // Time-out, sleep and watchdog clear events
        evt(3'b001);
        chk(flags[6:5], 2'b01);
        evt(3'b010);
        chk(flags[6:5], 2'b10);
        evt(3'b100);
        chk(flags[6:5], 2'b11);
        $display("event test done");
        // Call copies working, bank and flags into the shadows
        ldw(8'h5a);
        fsave = flags;
        ins = mk(csf_pkg::CSF_OP_NONE, csf_pkg::CSF_AM_NONE, 1'b0, 1'b0,
                 8'h00);
        ins.is_call = 1'b1;
        ins.call_target = 20'habcde;
        go(ins, 8'h00);
        tick();
        chk({sh_w, sh_b, sh_f}, {8'h5a, 6'h00, fsave});
        chk({tgt, call}, {20'habcde, 1'b1});
        go(nop, 8'h00);
        tick();
        chk(call, 1'b0);
        $display("call test done");
        // Banked, access-bank and long direct addresses
        go(mk(csf_pkg::CSF_OP_NONE, csf_pkg::CSF_AM_DIRECT, 1'b1, 1'b0,
              8'h34), 8'h00);
        chk(rd_addr, 14'h0034);
        go(mk(csf_pkg::CSF_OP_NONE, csf_pkg::CSF_AM_DIRECT, 1'b0, 1'b0,
              8'h70), 8'h00);
        chk(rd_addr, 14'h3f70);
        ins = mk(csf_pkg::CSF_OP_NONE, csf_pkg::CSF_AM_LONG, 1'b0, 1'b0,
                 8'h34);
        ins.long_addr = 14'h2345;
        go(ins, 8'h00);
        chk(rd_addr, 14'h2345);
        // Load pointer 0 with 12ffh; high byte top bits are dropped
        go(mk(csf_pkg::CSF_OP_MOV, csf_pkg::CSF_AM_DIRECT, 1'b0, 1'b1,
              8'he9), 8'hff);
        go(mk(csf_pkg::CSF_OP_MOV, csf_pkg::CSF_AM_DIRECT, 1'b0, 1'b1,
              8'hea), 8'hd2);
        tick();
        fsave = flags;
        acts = '{csf_pkg::CSF_PA_POST_INC, csf_pkg::CSF_PA_KEEP,
                 csf_pkg::CSF_PA_PRE_INC, csf_pkg::CSF_PA_KEEP,
                 csf_pkg::CSF_PA_POST_DEC, csf_pkg::CSF_PA_KEEP};
        pexp = '{14'h12ff, 14'h1300, 14'h1301, 14'h1301, 14'h1301, 14'h1300};
        for (int k = 0; k < 6; k++) begin
            ins = mk(csf_pkg::CSF_OP_NONE, csf_pkg::CSF_AM_IND, 1'b1, 1'b0,
                     8'h34);
            ins.ptr_act = acts[k];
            go(ins, 8'h00);
            chk(rd_addr, pexp[k]);
            tick();
        end
        chk(flags, fsave);
        $display("pointer test done");
        // Literal offset from pointer 2 only with the extended set
        go(mk(csf_pkg::CSF_OP_MOV, csf_pkg::CSF_AM_DIRECT, 1'b0, 1'b1,
              8'he3), 8'h40);
        go(mk(csf_pkg::CSF_OP_NONE, csf_pkg::CSF_AM_DIRECT, 1'b0, 1'b0,
              8'h05), 8'h00);
        chk(rd_addr, 14'h0005);
        @(negedge clk_i);
        ext_set_i = 1'b1;
        #1;
        chk(rd_addr, 14'h0045);
        go(mk(csf_pkg::CSF_OP_NONE, csf_pkg::CSF_AM_DIRECT, 1'b0, 1'b0,
              8'h70), 8'h00);
        chk(rd_addr, 14'h3f70);
        $display("literal offset test done");
        // Reset in mid-run acts at once, without waiting for an edge
        @(negedge clk_i);
        instr_i = nop;
        ext_set_i = 1'b0;
        sys_rst_i = 1'b1;
        #1;
        chk({flags, work}, 16'h6000);
        chk({sh_w, sh_f, call}, 17'h00000);
        @(negedge clk_i);
        sys_rst_i = 1'b0;
        // Idle edges after release must leave the reset flags alone
        tick();
        tick();
        chk(flags, 8'h60);
        $display("second reset test done");
        end_sim();
    end
endmodule : cpu_status_flags_and_data_addressing_test
